// [hdl/sarcc_ctrl.sv]
// SAR converter control with AXI4-Lite register slave
`timescale 1ns/1ps
module sarcc_ctrl
    import sarcc_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    input  wire logic [4:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [4:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY,
    input  wire logic [7:0]  TRIGGER_IN,
    input  wire logic [9:0]  ADC_CODE,
    output sarcc_core_t      CORE
);

    sarcc_state_t st_reg;
    sarcc_state_t st_next;
    logic [6:0]   presc_last;
    logic         tick;
    logic         trig_level;
    logic         trig_edge;
    logic         complete;
    logic         free_run;
    logic         do_write;
    logic         rd_take;

    // Gain stage setting for a channel code
    function automatic logic [1:0] chan_gain(input logic [4:0] ch);
        logic [1:0] g;
        g = GAIN_X1;
        if (ch[4:3] == 2'h0 || ch == CH_BANDGAP || ch == CH_GROUND) begin
            g = GAIN_BYPASS;
        end else if (ch[4:2] == 3'h2) begin
            g = GAIN_X10;
        end else if (ch[4:2] == 3'h3) begin
            g = GAIN_X200;
        end
        return g;
    endfunction : chan_gain

    // Register read mux
    function automatic logic [7:0] reg_read(input sarcc_state_t s, input logic [4:0] a);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            OFS_CTRL_A: d = {s.presc_sel, s.irq_en, s.done_flag, s.auto_trig,
                             s.busy | s.start_pend, s.enable};
            OFS_CTRL_B: d = {5'h00, s.trig_sel};
            OFS_INPUT:  d = {s.refsel, s.ladj, s.channel};
            OFS_RES_LO: d = s.res_lo;
            OFS_RES_HI: d = s.res_hi;
            default:    d = 8'h00;
        endcase
        return d;
    endfunction : reg_read

    function automatic logic is_mapped(input logic [4:0] a);
        return a == OFS_CTRL_A || a == OFS_CTRL_B || a == OFS_INPUT ||
               a == OFS_RES_LO || a == OFS_RES_HI;
    endfunction : is_mapped

    assign presc_last = 7'((8'h02 << st_reg.presc_sel) - 8'h01);
    assign tick       = st_reg.presc == presc_last;
    // Source 0 is the done flag itself; others are outside flags
    assign trig_level = (st_reg.trig_sel == TRIG_FREE_RUN) ? st_reg.done_flag
                                                           : st_reg.trig_sync[st_reg.trig_sel]; // RULE_16
    assign trig_edge  = trig_level && !st_reg.trig_prev; // RULE_25
    assign free_run   = st_reg.auto_trig && st_reg.trig_sel == TRIG_FREE_RUN;
    assign complete   = st_reg.enable && st_reg.busy && tick &&
                        st_reg.conv_cnt == (st_reg.first ? CONV_CYCLES_FIRST - 5'h01
                                                         : CONV_CYCLES_NORMAL - 5'h01); // RULE_22
    assign do_write   = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
    assign rd_take    = ARVALID && st_reg.arready;

    always_comb begin
        st_next = st_reg;
        st_next.trig_meta = TRIGGER_IN;
        st_next.trig_sync = st_reg.trig_meta;
        st_next.code_meta = ADC_CODE;
        st_next.code_sync = st_reg.code_meta;
        st_next.trig_prev = trig_level;

        // Write address and data taken in either order
        if (AWVALID && st_reg.awready) begin
            st_next.aw_full = 1'b1;
            st_next.aw_addr = AWADDR;
        end
        if (WVALID && st_reg.wready) begin
            st_next.w_full  = 1'b1;
            st_next.w_data  = WDATA[7:0];
            st_next.w_lane0 = WSTRB[0];
        end
        if (BREADY && st_reg.bvalid) begin
            st_next.bvalid = 1'b0;
        end
        if (do_write) begin
            st_next.aw_full = 1'b0;
            st_next.w_full  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = is_mapped(st_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (st_reg.w_lane0) begin
                case (st_reg.aw_addr)
                    OFS_CTRL_A: begin
                        st_next.enable    = st_reg.w_data[0];
                        st_next.auto_trig = st_reg.w_data[2];
                        st_next.irq_en    = st_reg.w_data[4];
                        st_next.presc_sel = st_reg.w_data[7:5];
                        if (st_reg.w_data[1] && !st_reg.busy) begin
                            st_next.start_pend = 1'b1; // RULE_07 RULE_20
                        end
                        if (st_reg.w_data[3]) begin
                            st_next.done_flag = 1'b0;
                        end
                    end
                    OFS_CTRL_B: st_next.trig_sel = st_reg.w_data[2:0];
                    OFS_INPUT: begin
                        st_next.channel = st_reg.w_data[4:0];
                        st_next.ladj    = st_reg.w_data[5];
                        st_next.refsel  = st_reg.w_data[7:6];
                    end
                    default: st_next.bresp = st_next.bresp;
                endcase
            end
        end

        // Reads; a low byte read locks, a high byte read unlocks
        if (RREADY && st_reg.rvalid) begin
            st_next.rvalid = 1'b0;
        end
        if (rd_take) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = is_mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
            st_next.rdata  = reg_read(st_reg, ARADDR);
            if (ARADDR == OFS_RES_LO) begin
                st_next.locked = 1'b1; // RULE_03
            end
            if (ARADDR == OFS_RES_HI) begin
                st_next.locked = 1'b0; // RULE_05
            end
        end

        // Conversion engine
        if (!st_reg.enable) begin
            st_next.presc    = 7'h00; // RULE_23
            st_next.busy     = 1'b0;
            st_next.first    = 1'b1;
            st_next.conv_cnt = 5'h00;
            if (!st_next.enable) begin
                st_next.start_pend = 1'b0;
            end
        end else begin
            st_next.presc = tick ? 7'h00 : st_reg.presc + 7'h01; // RULE_23
            if (!st_reg.busy) begin
                st_next.core.channel   = st_reg.channel; // RULE_09
                st_next.core.reference = st_reg.refsel; // RULE_12
            end
            if (!st_reg.busy && st_reg.auto_trig && st_reg.trig_sel != TRIG_FREE_RUN
                && trig_edge) begin
                st_next.presc      = 7'h00; // RULE_13
                st_next.busy       = 1'b1;
                st_next.start_pend = 1'b0;
                st_next.conv_cnt   = 5'h00;
            end else if (!st_reg.busy && st_reg.start_pend && tick) begin
                st_next.busy       = 1'b1; // RULE_07 RULE_19
                st_next.start_pend = 1'b0;
                st_next.conv_cnt   = 5'h00;
            end else if (complete) begin
                st_next.done_flag = 1'b1; // RULE_06 RULE_24
                st_next.first     = 1'b0;
                st_next.conv_cnt  = 5'h00;
                st_next.busy      = free_run; // RULE_18 RULE_24 RULE_14
                st_next.core.channel   = st_reg.channel; // RULE_08
                st_next.core.reference = st_reg.refsel;
                if (!st_reg.locked) begin
                    if (st_reg.ladj) begin
                        st_next.res_hi = st_reg.code_sync[9:2]; // RULE_01
                        st_next.res_lo = {st_reg.code_sync[1:0], 6'h00};
                    end else begin
                        st_next.res_hi = {6'h00, st_reg.code_sync[9:8]}; // RULE_01
                        st_next.res_lo = st_reg.code_sync[7:0];
                    end
                end // RULE_04
            end else if (st_reg.busy && tick) begin
                st_next.conv_cnt = st_reg.conv_cnt + 5'h01; // RULE_15
            end
        end

        st_next.core.enable     = st_next.enable;
        st_next.core.converting = st_next.busy;
        st_next.core.gain       = chan_gain(st_next.core.channel); // RULE_10 RULE_11
        st_next.awready         = !st_next.aw_full;
        st_next.wready          = !st_next.w_full;
        st_next.arready         = !st_next.rvalid;
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            st_reg <= SARCC_ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign AWREADY = st_reg.awready;
    assign WREADY  = st_reg.wready;
    assign BVALID  = st_reg.bvalid;
    assign BRESP   = st_reg.bresp;
    assign ARREADY = st_reg.arready;
    assign RVALID  = st_reg.rvalid;
    assign RRESP   = st_reg.rresp;
    assign RDATA   = {24'h000000, st_reg.rdata};
    assign CORE    = st_reg.core;

    default clocking dcb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);

    AST_LOCK_HOLDS: assert property (st_reg.locked |=> $stable(st_reg.res_lo) && $stable(st_reg.res_hi)) // RULE_04
        else $error("Result bytes changed while locked");
    AST_LOW_LOCKS: assert property (rd_take && ARADDR == OFS_RES_LO |=> st_reg.locked) // RULE_03
        else $error("Low byte read did not lock");
    AST_HIGH_UNLOCKS: assert property (rd_take && ARADDR == OFS_RES_HI |=> !st_reg.locked) // RULE_05
        else $error("High byte read did not unlock");
    AST_DONE_SETS: assert property (complete |=> st_reg.done_flag && st_reg.conv_cnt == 5'h00) // RULE_06
        else $error("Done flag not set on completion");
    AST_SINGLE_ENDS: assert property (complete && !free_run |=> !st_reg.busy && !st_reg.start_pend) // RULE_24
        else $error("Start bit not cleared after single conversion");
    AST_FREE_RUN: assert property (complete && free_run |=> st_reg.busy && st_reg.presc == 7'h00) // RULE_18
        else $error("Free running did not restart");
    AST_EDGE_IGNORED: assert property (st_reg.enable && st_reg.busy && trig_edge && !tick && !complete // RULE_15
                                       |=> st_reg.presc == $past(st_reg.presc) + 7'h01)
        else $error("Trigger edge disturbed running conversion");
    AST_TRIG_START: assert property (!st_reg.busy && st_reg.enable && st_reg.auto_trig && trig_edge // RULE_13
                                     && st_reg.trig_sel != TRIG_FREE_RUN |=> st_reg.busy && st_reg.presc == 7'h00)
        else $error("Trigger edge did not start conversion");
    AST_CHAN_HELD: assert property (st_reg.busy && !complete |=> $stable(st_reg.core.channel)) // RULE_08
        else $error("Channel changed during conversion");
    AST_DISABLED: assert property (!st_reg.enable |=> st_reg.presc == 7'h00 && !st_reg.busy) // RULE_23
        else $error("Prescaler ran while disabled");

    AST_GAIN_SINGLE: assert property ( // RULE_10
        st_reg.core.channel[4:3] == 2'h0 || st_reg.core.channel >= CH_BANDGAP
        |-> st_reg.core.gain == GAIN_BYPASS)
        else $error("Gain stage not bypassed on a single ended input");
    AST_GAIN_X10: assert property (st_reg.core.channel[4:2] == 3'h2 // RULE_11
        |-> st_reg.core.gain == GAIN_X10)
        else $error("Wrong gain for a x10 pair");
    AST_GAIN_X200: assert property (st_reg.core.channel[4:2] == 3'h3 // RULE_11
        |-> st_reg.core.gain == GAIN_X200)
        else $error("Wrong gain for a x200 pair");
    AST_GAIN_X1: assert property (st_reg.core.channel[4] && st_reg.core.channel < CH_BANDGAP // RULE_11
        |-> st_reg.core.gain == GAIN_X1)
        else $error("Wrong gain for a x1 pair");
    AST_SEL_FOLLOWS: assert property (st_reg.enable && !st_reg.busy // RULE_09
        |=> st_reg.core.channel == $past(st_reg.channel) && st_reg.core.reference == $past(st_reg.refsel))
        else $error("Selection not applied while enabled and idle");
    AST_SEL_DISABLED: assert property (!st_reg.enable // RULE_09
        |=> $stable(st_reg.core.channel) && $stable(st_reg.core.reference))
        else $error("Selection changed while disabled");
    AST_REF_HELD: assert property (st_reg.busy && !complete // RULE_08
        |=> $stable(st_reg.core.reference))
        else $error("Reference changed during conversion");
    AST_BUSY_HOLDS: assert property (st_reg.enable && st_reg.busy && !complete // RULE_07
        |=> st_reg.busy)
        else $error("Start bit dropped before completion");
    AST_NO_STRAY_START: assert property (!st_reg.busy && !st_reg.start_pend && !trig_edge // RULE_14
        |=> !st_reg.busy)
        else $error("Conversion started without start bit or trigger edge");
    AST_TRIG_ONCE: assert property (trig_edge // RULE_25
        |=> !trig_edge)
        else $error("Trigger edge seen twice");
    AST_RES_RIGHT: assert property (complete && !st_reg.locked && !st_reg.ladj // RULE_01
        |=> st_reg.res_hi[7:2] == 6'h00)
        else $error("Right aligned high byte has stray bits");
    AST_RES_LEFT: assert property (complete && !st_reg.locked && st_reg.ladj // RULE_01
        |=> st_reg.res_lo[5:0] == 6'h00)
        else $error("Left aligned low byte has stray bits");
    AST_START_READS_BUSY: assert property (st_reg.busy && rd_take && ARADDR == OFS_CTRL_A // RULE_20
        |=> st_reg.rdata[1])
        else $error("Start bit did not read one during conversion");
    AST_DONE_STAYS: assert property (st_reg.done_flag && !(do_write && st_reg.aw_addr == OFS_CTRL_A // RULE_06
        && st_reg.w_lane0 && st_reg.w_data[3]) |=> st_reg.done_flag)
        else $error("Done flag lost without a clear");
    AST_WRITE_ANSWERS: assert property (do_write |=> st_reg.bvalid)
        else $error("Write not answered");
    AST_READ_ANSWERS: assert property (rd_take |=> st_reg.rvalid)
        else $error("Read not answered");

    COV_SINGLE: cover property (st_reg.start_pend ##[1:1000] complete);
    COV_LOCK_DROP: cover property (complete && st_reg.locked);
    COV_FREE_RUN: cover property (complete && free_run);
    COV_TRIGGER: cover property (st_reg.auto_trig && trig_edge && !st_reg.busy && st_reg.enable);
    COV_EDGE_IGNORED: cover property (st_reg.auto_trig && trig_edge && st_reg.busy);
endmodule : sarcc_ctrl

// [hdl/sarcc_pkg.sv]
// Constants and types for the SAR converter control block
// Behaviour
// RULE_01 - Result is 10 bits over two bytes, right or left aligned
// RULE_02 - Software reads low byte first, then high byte
// RULE_03 - Reading the low byte locks both result bytes
// RULE_04 - A result completing while locked is dropped
// RULE_05 - Reading the high byte unlocks the result bytes
// RULE_06 - Done flag sets on every completion, even dropped ones
// RULE_07 - Start bit begins a conversion, clears when it ends
// RULE_08 - Channel change applies only after the running conversion
// RULE_09 - Channel and reference take effect only while enabled
// RULE_10 - Channel field picks single, ground, bandgap or differential input
// RULE_11 - Differential pairs offer gains 1x, 10x and 200x
// RULE_12 - Reference field picks pin, supply, 2.56V or 1.1V
// RULE_13 - Trigger rising edge resets prescaler and starts conversion
// RULE_14 - Trigger still high at completion starts nothing
// RULE_15 - Trigger edges during a conversion are ignored
// RULE_16 - Trigger flags set regardless of interrupt enables
// RULE_17 - Software clears a flag trigger before its next event
// RULE_18 - Done flag trigger restarts at once, flag cleared or not
// RULE_19 - Software starts free running with the start bit
// RULE_20 - Start bit works with auto trigger, reads busy always
// RULE_21 - Software should disable the converter before sleep
// RULE_22 - Conversion takes 13 converter clocks, first one 25
// RULE_23 - Prescaler runs while enabled, held in reset otherwise
// RULE_24 - Completion writes result, sets flag, clears start bit
// RULE_25 - Trigger edge found by comparing successive clock samples
package sarcc_pkg;
    localparam logic [4:0] OFS_CTRL_A  = 5'h00;
    localparam logic [4:0] OFS_CTRL_B  = 5'h04;
    localparam logic [4:0] OFS_INPUT   = 5'h08;
    localparam logic [4:0] OFS_RES_LO  = 5'h0C;
    localparam logic [4:0] OFS_RES_HI  = 5'h10;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [4:0] CONV_CYCLES_NORMAL = 5'h0D;
    localparam logic [4:0] CONV_CYCLES_FIRST  = 5'h19;
    localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
    localparam logic [4:0] CH_BANDGAP  = 5'h1E;
    localparam logic [4:0] CH_GROUND   = 5'h1F;
    localparam logic [1:0] GAIN_BYPASS = 2'h0;
    localparam logic [1:0] GAIN_X1     = 2'h1;
    localparam logic [1:0] GAIN_X10    = 2'h2;
    localparam logic [1:0] GAIN_X200   = 2'h3;

    typedef struct packed {
        logic       enable;
        logic       converting;
        logic [4:0] channel;
        logic [1:0] reference;
        logic [1:0] gain;
    } sarcc_core_t;

    typedef struct packed {
        logic        enable;
        logic        start_pend;
        logic        busy;
        logic        auto_trig;
        logic        done_flag;
        logic        irq_en;
        logic [2:0]  presc_sel;
        logic [2:0]  trig_sel;
        logic [4:0]  channel;
        logic        ladj;
        logic [1:0]  refsel;
        logic        first;
        logic [6:0]  presc;
        logic [4:0]  conv_cnt;
        logic        locked;
        logic [7:0]  res_lo;
        logic [7:0]  res_hi;
        logic [7:0]  trig_meta;
        logic [7:0]  trig_sync;
        logic        trig_prev;
        logic [9:0]  code_meta;
        logic [9:0]  code_sync;
        logic        aw_full;
        logic [4:0]  aw_addr;
        logic        w_full;
        logic [7:0]  w_data;
        logic        w_lane0;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [7:0]  rdata;
        sarcc_core_t core;
    } sarcc_state_t;

    localparam sarcc_state_t SARCC_ST_RESET = '{first: 1'b1, awready: 1'b1, wready: 1'b1,
                                                arready: 1'b1, default: '0};
endpackage : sarcc_pkg

// [verif/sarcc_core_model.sv]
// Behavioural model of the analog conversion core and the trigger sources
`timescale 1ns/1ps
module sarcc_core_model
    import sarcc_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire sarcc_core_t core,
    input  wire logic [7:0]  trig_req,
    output logic [9:0]       code,
    output logic [7:0]       trig
);
    logic [9:0] sample;

    initial code = 10'h155;
    // Code encodes the locked channel and reference
    assign sample = {core.channel, core.reference, 3'h5};
    // Code holds while converting, toggles every cycle otherwise
    always @(posedge CLOCK) begin
        if (core.converting) begin
            code <= sample;
        end else begin
            code <= ~code;
        end
    end
    // Flags follow their events whatever the interrupt enables
    assign trig = trig_req;
endmodule : sarcc_core_model

// [verif/sar_adc_conversion_control_tb_top.sv]
// Self-checking bench for the SAR converter control block
`timescale 1ns/1ps
module sar_adc_conversion_control_tb_top;
    import sarcc_pkg::*;
    logic        clock     = 1'b0;
    logic        srst      = 1'b1;
    logic [4:0]  awaddr    = 5'h00;
    logic        awvalid   = 1'b0;
    logic [31:0] wdata     = 32'h0;
    logic        wvalid    = 1'b0;
    logic [4:0]  araddr    = 5'h00;
    logic        arvalid   = 1'b0;
    logic [7:0]  trig_req  = 8'h00;
    logic        busy_prev = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [9:0]  adc_code, e;
    logic [7:0]  trig;
    sarcc_core_t core;
    int          n_errors = 0;
    int          comparisons = 0;
    int          n_conv = 0;
    int          run = 0;
    int          last_len = 0;
    int          n0;

    sarcc_ctrl dut (.CLOCK(clock), .SRST(srst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(1'b1), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rvalid), .RREADY(1'b1), .TRIGGER_IN(trig), .ADC_CODE(adc_code), .CORE(core));
    sarcc_core_model core_model (.CLOCK(clock), .core(core), .trig_req(trig_req), .code(adc_code), .trig(trig));

    initial begin
        forever #20 clock = ~clock;
    end

    // Counts conversions and the length of the last one
    always @(negedge clock) begin
        if (core.converting && !busy_prev) begin
            n_conv++;
            run = 0;
        end
        if (core.converting) begin
            run++;
        end else if (busy_prev) begin
            last_len = run;
        end
        busy_prev = core.converting;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic axi_write(input logic [4:0] a, input logic [7:0] v);
        logic aa, ww, bv;
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h0, v};
        wvalid  <= 1'b1;
        do begin
            @(negedge clock);
            aa = awready;
            ww = wready;
            bv = bvalid;
            r  = bresp;
            @(posedge clock);
            if (aa && awvalid) awvalid <= 1'b0;
            if (ww && wvalid) wvalid <= 1'b0;
        end while (bv !== 1'b1);
    endtask : axi_write

    task automatic axi_read(input logic [4:0] a);
        logic ar, rv;
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge clock);
            ar = arready;
            rv = rvalid;
            d  = rdata;
            r  = rresp;
            @(posedge clock);
            if (ar && arvalid) arvalid <= 1'b0;
        end while (rv !== 1'b1);
    endtask : axi_read

    task automatic wait_done();
        do begin
            axi_read(OFS_CTRL_A);
        end while (d[3] !== 1'b1);
    endtask : wait_done

    task automatic read_result(input logic [31:0] lo, input logic [31:0] hi);
        axi_read(OFS_RES_LO);
        chk(d, lo, "result low");
        axi_read(OFS_RES_HI);
        chk(d, hi, "result high");
    endtask : read_result

    task automatic t_regs();
        axi_read(OFS_CTRL_A);
        chk(d, 32'h0, "control reset");
        chk(32'(r), 32'(RESP_OKAY), "mapped read resp");
        axi_read(5'h14);
        chk(d, 32'h0, "unmapped read data");
        chk(32'(r), 32'(RESP_SLVERR), "unmapped read resp");
        axi_write(5'h14, 8'hFF);
        chk(32'(r), 32'(RESP_SLVERR), "unmapped write resp");
        axi_write(OFS_INPUT, 8'h42);
        @(negedge clock);
        chk(32'(core.channel), 32'h0, "channel while disabled");
        @(posedge clock);
    endtask : t_regs

    task automatic t_single();
        axi_write(OFS_CTRL_A, 8'h01);
        @(negedge clock);
        chk(32'(core.channel), 32'h2, "channel once enabled");
        chk(32'(r), 32'(RESP_OKAY), "mapped write resp");
        @(posedge clock);
        axi_write(OFS_CTRL_A, 8'h03);
        axi_read(OFS_CTRL_A);
        chk(32'(d[1]), 32'h1, "start reads busy");
        wait_done();
        chk(32'(d[1]), 32'h0, "start cleared at completion");
        chk(last_len, 32'd50, "first conversion length");
        e = {5'h02, 2'h1, 3'h5};
        read_result({24'h0, e[7:0]}, {30'h0, e[9:8]});
    endtask : t_single

    task automatic t_lock();
        axi_write(OFS_INPUT, 8'h65);
        axi_write(OFS_CTRL_A, 8'h0B);
        axi_write(OFS_INPUT, 8'h66);
        @(negedge clock);
        chk(32'(core.channel), 32'h5, "channel held in conversion");
        @(posedge clock);
        wait_done();
        chk(last_len, 32'd26, "normal conversion length");
        chk(32'(core.channel), 32'h6, "channel after conversion");
        e = {5'h05, 2'h1, 3'h5};
        axi_read(OFS_RES_LO);
        chk(d, {24'h0, e[1:0], 6'h00}, "left low locks");
        axi_write(OFS_CTRL_A, 8'h0B);
        wait_done();
        axi_read(OFS_RES_HI);
        chk(d, {24'h0, e[9:2]}, "locked high kept");
        axi_write(OFS_CTRL_A, 8'h0B);
        wait_done();
        e = {5'h06, 2'h1, 3'h5};
        read_result({24'h0, e[1:0], 6'h00}, {24'h0, e[9:2]});
    endtask : t_lock

    task automatic t_trig();
        axi_write(OFS_CTRL_B, 8'h03);
        axi_write(OFS_CTRL_A, 8'h0D);
        n0 = n_conv;
        trig_req[3] <= 1'b1;
        do @(negedge clock); while (core.converting !== 1'b1);
        @(posedge clock);
        trig_req[3] <= 1'b0;
        repeat (3) @(posedge clock);
        trig_req[3] <= 1'b1;
        wait_done();
        repeat (60) @(posedge clock);
        chk(n_conv - n0, 32'd1, "edge in conversion or high level");
        trig_req[3] <= 1'b0;
        axi_write(OFS_CTRL_A, 8'h0D);
        trig_req[3] <= 1'b1;
        wait_done();
        chk(n_conv - n0, 32'd2, "new edge starts");
        axi_write(OFS_CTRL_A, 8'h0F);
        axi_read(OFS_CTRL_A);
        chk(32'(d[1]), 32'h1, "start with auto trigger busy");
        wait_done();
        chk(n_conv - n0, 32'd3, "start with auto trigger runs");
        trig_req[3] <= 1'b0;
    endtask : t_trig

    task automatic t_free();
        axi_write(OFS_CTRL_B, 8'h00);
        axi_write(OFS_CTRL_A, 8'h0F);
        wait_done();
        axi_write(OFS_INPUT, 8'h67);
        repeat (120) @(posedge clock);
        e = {5'h07, 2'h1, 3'h5};
        read_result({24'h0, e[1:0], 6'h00}, {24'h0, e[9:2]});
        axi_write(OFS_CTRL_A, 8'h00);
        @(negedge clock);
        chk(32'(core.enable), 32'h0, "disabled");
        n0 = n_conv;
        repeat (60) @(posedge clock);
        chk(n_conv - n0, 32'd0, "no conversion while disabled");
    endtask : t_free

    task automatic t_gain();
        axi_write(OFS_CTRL_A, 8'h01);
        axi_write(OFS_INPUT, 8'hC9);
        @(negedge clock);
        chk(32'(core.gain), 32'(GAIN_X10), "gain of a x10 pair");
        chk(32'(core.reference), 32'h3, "reference applied");
        @(posedge clock);
        axi_write(OFS_INPUT, 8'h0D);
        @(negedge clock);
        chk(32'(core.gain), 32'(GAIN_X200), "gain of a x200 pair");
        @(posedge clock);
        axi_write(OFS_INPUT, 8'h14);
        @(negedge clock);
        chk(32'(core.gain), 32'(GAIN_X1), "gain of a x1 pair");
        @(posedge clock);
        axi_write(OFS_INPUT, 8'h1E);
        @(negedge clock);
        chk(32'(core.gain), 32'(GAIN_BYPASS), "gain on bandgap");
        @(posedge clock);
        axi_write(OFS_INPUT, 8'h03);
        @(negedge clock);
        chk(32'(core.gain), 32'(GAIN_BYPASS), "gain on single input");
    endtask : t_gain

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        t_regs();
        t_single();
        t_lock();
        t_trig();
        t_free();
        t_gain();
        results();
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        $display("Error %0t: watchdog expired", $time);
        results();
    end
endmodule : sar_adc_conversion_control_tb_top
